// ### rtl/mqe_decoder.sv
`timescale 1ns/1ns
`default_nettype none
`include "mqe_map.svh"

module mqe_decoder
  import mqe_pkg::*;
#(
  parameter int LOST_CYC = `MQE_LOST_CYC
)
(
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  mqe_link_if.decoder              link,
  input  wire logic                seed_req,
  output mqe_pkg::mqe_count_t      quad_count,
  output mqe_pkg::mqe_angle_t      pw_angle,
  output logic                     pw_valid,
  output logic                     sensor_lost
);
  import mqe_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // pins pass two flops before any logic reads them
  logic [2:0] pins_s;
  logic       a_s;
  logic       b_s;
  logic       pw_s;

  mqe_sync2 #(.W(3)) u_sync
  (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .d       ({link.quad_a, link.quad_b, link.pw_out}),
    .q       (pins_s)
  );

  assign a_s  = pins_s[2];
  assign b_s  = pins_s[1];
  assign pw_s = pins_s[0];

  ////////////////////////////////////////////////////////////////////////
  // quadrature counting
  logic [1:0] ab_q;
  logic       up;
  logic       dn;
  mqe_count_t count_q;
  logic       seed_ok;

  // last settled A/B pair, the reference for the next edge

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ab_q <= 2'b00;
    else
      ab_q <= pins_s[2:1];
  end

  // A leads: up, B leads: down, both moving at once: ignored
  always_comb
  begin
    up = 1'b0;
    dn = 1'b0;
    case ({ab_q, a_s, b_s})
      4'h2: up = 1'b1;
      4'hb: up = 1'b1;
      4'hd: up = 1'b1;
      4'h4: up = 1'b1;
      4'h1: dn = 1'b1;
      4'h7: dn = 1'b1;
      4'he: dn = 1'b1;
      4'h8: dn = 1'b1;
      default:
      begin
        up = 1'b0;
        dn = 1'b0;
      end
    endcase
  end

  // seed only from a decoded value
  assign seed_ok = seed_req && pw_valid;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      count_q <= `MQE_CNT_RST;
    else if (seed_ok)
      // load absolute angle as count, caller seeds only at rest
      count_q <= mqe_count_t'(pw_angle[`MQE_ANGLE_W-1:2]);
    else if (up)
      count_q <= count_q + 32'd1;
    else if (dn)
      count_q <= count_q - 32'd1;
  end
  // count follows every edge, the source for velocity at speed
  assign quad_count = count_q;

  ////////////////////////////////////////////////////////////////////////
  // pulse width timing
  mqe_pw_state_t st_q;
  logic [31:0]   width_q;
  logic [31:0]   idle_q;
  mqe_angle_t    angle_q;
  logic          valid_q;
  logic          lost_q;
  logic          pw_rise;
  logic          pw_fall;

  // pulse edges as the state machine sees them
  assign pw_rise = (st_q == MQE_PW_LOW) && pw_s;
  assign pw_fall = (st_q == MQE_PW_HIGH) && !pw_s;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= MQE_PW_IDLE;
    else
    begin
      case (st_q)
        // wait for pw_s low, which the synchronizer reset gives at the first edge, so a pulse cut by reset is timed
        MQE_PW_IDLE:
          if (!pw_s)
            st_q <= MQE_PW_LOW;
        MQE_PW_LOW:
          if (pw_s)
            st_q <= MQE_PW_HIGH;
        MQE_PW_HIGH:
          if (!pw_s)
            st_q <= MQE_PW_LOW;
        default:
          st_q <= MQE_PW_IDLE;
      endcase
    end
  end

  // high time in cycles, counted from the first high sample
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      width_q <= '0;
    else if (pw_rise)
      width_q <= 32'd1;
    else if (st_q == MQE_PW_HIGH && pw_s)
      width_q <= width_q + 32'd1;
  end

  // value taken only once the pulse has ended
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      angle_q <= '0;
    else if (pw_fall)
      angle_q <= mqe_angle_t'((width_q - 32'(`MQE_PW_MIN_CYC))
                              / 32'(`MQE_PW_SCALE));
  end

  // a fresh value wins over a loss flagged in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      valid_q <= 1'b0;
    else if (pw_fall)
      valid_q <= 1'b1;
    else if (lost_q)
      valid_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // no rising edge within the window marks sensor absent
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      idle_q <= '0;
    else if (pw_rise)
      idle_q <= '0;
    else if (idle_q < 32'(LOST_CYC - 1))
      idle_q <= idle_q + 32'd1;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      lost_q <= 1'b0;
    else if (pw_rise)
      lost_q <= 1'b0;
    else if (idle_q >= 32'(LOST_CYC - 1))
      lost_q <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  assign pw_angle    = angle_q;
  assign pw_valid    = valid_q;
  assign sensor_lost = lost_q;
endmodule

`default_nettype wire

// ### rtl/mqe_encoder.sv
`timescale 1ns/1ns
`default_nettype none
`include "mqe_map.svh"

module mqe_encoder
  import mqe_pkg::*;
#(
  parameter int REFRESH_CYC = `MQE_REFRESH_CYC
)
(
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire mqe_pkg::mqe_angle_t angle,
  mqe_link_if.encoder             link
);
  import mqe_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // quadrature: track angle one count per step, 4 counts per A/B cycle
  mqe_angle_t pos_q;
  logic [1:0] ab_q;
  logic       booted_q;
  mqe_angle_t tgt;

  // 4096 angle steps over 1024 counts
  assign tgt = angle;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      booted_q <= 1'b0;
      pos_q    <= '0;
      ab_q     <= 2'h0;
    end
    else if (!booted_q)
    begin
      booted_q <= 1'b1;
      pos_q    <= tgt;  // boot position is quadrature zero
    end
    else if (pos_q[`MQE_ANGLE_W-1:2] != tgt[`MQE_ANGLE_W-1:2])
    begin
      // one count per clock, shortest way round
      if (mqe_angle_t'(tgt - pos_q) < mqe_angle_t'(1 << (`MQE_ANGLE_W-1)))
      begin
        pos_q   <= pos_q + mqe_angle_t'(4);
        ab_q    <= {~ab_q[0], ab_q[1]};
      end
      else
      begin
        pos_q   <= pos_q - mqe_angle_t'(4);
        ab_q    <= {ab_q[0], ~ab_q[1]};
      end
    end
  end

  // A,B steps 00,10,11,01 counting up, so A leads B
  assign link.quad_a = ab_q[1];
  assign link.quad_b = ab_q[0];

  ////////////////////////////////////////////////////////////////////////
  // pulse width: high time proportional to absolute angle, every frame
  logic [31:0] frame_q;
  logic [31:0] high_q;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // first edge opens a frame carrying the boot angle
      frame_q <= 32'(REFRESH_CYC - 1);
      high_q  <= 32'h0000_0001;
    end
    else if (frame_q == 32'(REFRESH_CYC - 1))
    begin
      frame_q <= '0;
      // new angle latched once per frame
      high_q  <= 32'(`MQE_PW_MIN_CYC) + 32'(angle) * 32'(`MQE_PW_SCALE);
    end
    else
    begin
      frame_q <= frame_q + 32'd1;
    end
  end

  // a pulse every frame regardless of motion
  logic pw_q;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      pw_q <= 1'b0;
    else
      pw_q <= (frame_q < high_q);
  end
  assign link.pw_out = pw_q;
endmodule

`default_nettype wire

// ### rtl/mqe_link_if.sv
`timescale 1ns/1ns
`default_nettype none

interface mqe_link_if;
  logic quad_a;
  logic quad_b;
  logic pw_out;

  modport encoder
  (
    output quad_a,
    output quad_b,
    output pw_out
  );

  modport decoder
  (
    input quad_a,
    input quad_b,
    input pw_out
  );
endinterface

`default_nettype wire

// ### rtl/mqe_map.svh
`ifndef MQE_MAP_SVH
`define MQE_MAP_SVH

`define MQE_CLK_MHZ        100
`define MQE_CPR            1024
`define MQE_ANGLE_W        12
`define MQE_REFRESH_US     4000
`define MQE_REFRESH_CYC    (`MQE_REFRESH_US * `MQE_CLK_MHZ)
`define MQE_PW_MIN_CYC     1
`define MQE_PW_SCALE       96
`define MQE_LOST_US        10000
`define MQE_LOST_CYC       (`MQE_LOST_US * `MQE_CLK_MHZ)
`define MQE_CNT_RST        32'h0000_0000

`endif

// ### rtl/mqe_pkg.sv
`include "mqe_map.svh"

package mqe_pkg;
  typedef logic [`MQE_ANGLE_W-1:0] mqe_angle_t;
  typedef logic [31:0]             mqe_count_t;
  typedef enum logic [2:0]
  {
    MQE_PW_IDLE = 3'b001,
    MQE_PW_HIGH = 3'b010,
    MQE_PW_LOW  = 3'b100
  } mqe_pw_state_t;
endpackage

// ### rtl/mqe_sync2.sv
`timescale 1ns/1ns
`default_nettype none

module mqe_sync2
#(
  parameter int W = 3
)
(
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      q      <= '0;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

`default_nettype wire

// ### verif/mqe_link_asserts.sv
`timescale 1ns/1ns
`default_nettype none
`include "mqe_map.svh"

module mqe_link_asserts
#(
  parameter int REFRESH_CYC = `MQE_REFRESH_CYC
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic quad_a,
  input wire logic quad_b,
  input wire logic pw_out
);
  localparam int MAX_HI = 1 + 4095 * `MQE_PW_SCALE;
  logic [31:0] gap_q;
  logic [31:0] hi_q;
  logic        seen_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // cycles since the last pulse start, and length of the current pulse
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      gap_q  <= '0;
      hi_q   <= '0;
      seen_q <= 1'b0;
    end
    else
    begin
      gap_q  <= $rose(pw_out) ? 32'h0 : gap_q + 32'h1;
      hi_q   <= pw_out ? hi_q + 32'h1 : 32'h0;
      seen_q <= seen_q | $rose(pw_out);
    end

  ////////////////////////////////////////////////////////////////////////////
  property p_single_edge;
    !($changed(quad_a) && $changed(quad_b));
  endproperty
  a_single_edge: assert property (p_single_edge)
    else $error("both quadrature lines changed at once");
  property p_boot_zero;
    $rose(rst_n) |-> (!quad_a && !quad_b)[*2];
  endproperty
  a_boot_zero: assert property (p_boot_zero)
    else $error("quadrature moved before boot position taken");
  property p_alive;
    gap_q <= REFRESH_CYC;
  endproperty
  a_alive: assert property (p_alive)
    else $error("pulse missing for more than a frame");
  property p_period;
    seen_q && $rose(pw_out) |-> gap_q == REFRESH_CYC - 1;
  endproperty
  a_period: assert property (p_period)
    else $error("pulse frame period wrong");
  property p_width;
    pw_out |-> hi_q < MAX_HI;
  endproperty
  a_width: assert property (p_width)
    else $error("pulse longer than full scale");
  property p_fall_in_frame;
    $fell(pw_out) |-> gap_q < REFRESH_CYC;
  endproperty
  a_fall_in_frame: assert property (p_fall_in_frame)
    else $error("pulse ended outside its frame");
  property p_frame_end_low;
    pw_out && seen_q && gap_q == REFRESH_CYC - 1 |-> $rose(pw_out);
  endproperty
  a_frame_end_low: assert property (p_frame_end_low)
    else $error("pulse still high at frame end");
  property p_pw_with_quad;
    $changed(quad_a) || $changed(quad_b) |-> gap_q < REFRESH_CYC;
  endproperty
  a_pw_with_quad: assert property (p_pw_with_quad)
    else $error("pulse output stalled while quadrature moves");
  c_pulse: cover property ($rose(pw_out));
  c_a_edge: cover property ($changed(quad_a));
  c_b_edge: cover property ($changed(quad_b));
endmodule

`default_nettype wire

// ### verif/tb_encoder_quad_pwm_output.sv
`timescale 1ns/1ns
`default_nettype none

module tb_encoder_quad_pwm_output;
  import mqe_pkg::*;
  localparam int RC = 5000;
  localparam int LC = 8000;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       seed_req = 1'b0;
  mqe_angle_t angle;
  mqe_angle_t boot;
  mqe_count_t quad_count;
  mqe_angle_t pw_angle;
  logic       pw_valid;
  logic       sensor_lost;
  logic       lost2;
  int         errors = 0;
  int         num_checks = 0;
  mqe_link_if link ();
  mqe_link_if link2 ();

  mqe_encoder #(.REFRESH_CYC(RC)) u_mqe_encoder (.sys_clk(sys_clk),
    .rst_n(rst_n), .angle(angle), .link(link.encoder));
  mqe_decoder #(.LOST_CYC(LC)) u_mqe_decoder (.sys_clk(sys_clk),
    .rst_n(rst_n), .link(link.decoder), .seed_req(seed_req),
    .quad_count(quad_count), .pw_angle(pw_angle), .pw_valid(pw_valid),
    .sensor_lost(sensor_lost));
  // second decoder on a cable with nothing attached
  mqe_decoder #(.LOST_CYC(LC)) u_mqe_decoder_lost (.sys_clk(sys_clk),
    .rst_n(rst_n), .link(link2.decoder), .seed_req(1'b0),
    .quad_count(), .pw_angle(), .pw_valid(), .sensor_lost(lost2));
  mqe_link_asserts #(.REFRESH_CYC(RC)) u_mqe_link_asserts (
    .sys_clk(sys_clk), .rst_n(rst_n), .quad_a(link.quad_a),
    .quad_b(link.quad_b), .pw_out(link.pw_out));

  always #5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask

  function automatic mqe_count_t rel(input mqe_angle_t a, input mqe_angle_t b);
    return mqe_count_t'(a[11:2]) - mqe_count_t'(b[11:2]);
  endfunction

  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic conclude;
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int d;
    void'($urandom(48));
    link2.quad_a = 1'b0;
    link2.quad_b = 1'b0;
    link2.pw_out = 1'b0;
    boot = mqe_angle_t'($urandom_range(36));
    angle = boot;
    step(16);
    rst_n = 1'b1;
    chk("count_rst", 32'h0, quad_count);
    chk("valid_rst", 32'h0, pw_valid);
    step(2);
    for (int i = 0; i < 300; i++)
    begin
      d = int'(angle) + int'($urandom_range(8)) - 4;
      if (d >= 0 && d <= 36)
        angle = mqe_angle_t'(d);
      step(6);
      chk("count", rel(angle, boot), quad_count);
    end
    step(2 * RC + 20);
    chk("pw_angle", angle, pw_angle);
    chk("pw_valid", 32'h1, pw_valid);
    seed_req = 1'b1;
    step(1);
    seed_req = 1'b0;
    step(4);
    chk("seed", angle[11:2], quad_count);
    angle = angle + 12'h004;
    step(6);
    chk("seed_move", angle[11:2], quad_count);
    chk("lost", 32'h1, lost2);
    chk("present", 32'h0, sensor_lost);
    conclude();
  end

  initial
  begin
    repeat (50000) @(posedge sys_clk);
    errors++;
    conclude();
  end
endmodule

`default_nettype wire
